/* shared/mrd_pkg.sv */
// package with constants and carrier types for the module register block decoder
package mrd_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned OFFS_W = 12;
  localparam logic [11:0] BASE_LOW_HI  = 12'h7FF;
  localparam logic [11:0] BASE_HIGH_HI = 12'hFFF;
  localparam logic [11:0] CFG_OFFSET   = 12'h000;
  localparam logic [11:0] PRIV_OFFSET  = 12'h002;
  localparam int unsigned MAP_SEL_POS  = 6;
  localparam logic        MAP_SEL_RST  = 1'b1;
  localparam logic [15:0] PRIV_RST     = 16'h0000;
  localparam logic [15:0] CFG_RST      = 16'h0040;
  // supervisor-only offset classes of the register map
  localparam logic [11:0] SUP_LOW_END    = 12'h00A;
  localparam logic [11:0] SUP_SINGLE_A   = 12'h016;
  localparam logic [11:0] SUP_SINGLE_B   = 12'h01E;
  localparam logic [11:0] SUP_SYS_FIRST  = 12'h020;
  localparam logic [11:0] SUP_SYS_LAST   = 12'h02C;
  localparam logic [11:0] SUP_TEST_FIRST = 12'h030;
  localparam logic [11:0] SUP_TEST_LAST  = 12'h038;
  localparam logic [11:0] SUP_HIGH_FIRST = 12'h044;
  // reset values of the decoded select and address-line registers
  localparam logic [11:0] SEL_OFFSET_RST = 12'h000;
  localparam logic [15:0] SEL_WDATA_RST  = 16'h0000;
  localparam logic [3:0]  EXT_HI_RST     = 4'h0;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              supervisor;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mrd_req_type;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } mrd_rsp_type;
endpackage : mrd_pkg

/* core/mrd_decode.sv */
// address decode and access control for the module control register block
//
// Summary of operation
// (R1) decode one 4-Kbyte region holding control registers of all modules
// (R2) map-select zero: respond at 7FF000 through 7FFFFF
// (R3) map-select one: respond at FFF000 through FFFFFF
// (R4) map-select resets to one; only first write after reset takes effect
// (R5) init software writes one to map-select in its single write
// (R6) narrow-core parts: address lines 23:20 copy line 19 unless driven
// (R7) narrow core with map-select cleared: block unreachable until reset
// (R8) supervisor-only registers accept only supervisor-level accesses
// (R9) supervisor-or-user registers have programmable privilege level
// (R10) narrow-core master presents every access at supervisor level
// (R11) offsets relative to base whose top bits come from map-select
// (R12) internal bus carries 24 address and 16 data lines
// (R13) select by comparing bits 23:12 with 7FF or FFF; 11:0 is offset
`timescale 1ns/1ps
module mrd_decode (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // variant strap: high on parts with the 16-bit core
  input  wire logic                narrow_core,
  // external address drive for lines 23:20
  input  wire logic                ext_hi_drive,
  input  wire logic [3:0]          ext_hi_addr,
  // intermodule bus request and answer
  input  wire mrd_pkg::mrd_req_type bus_req,
  output mrd_pkg::mrd_rsp_type      bus_rsp,
  // decoded register access toward the modules
  output logic                     sel_valid,
  output logic                     sel_write,
  output logic [11:0]              sel_offset,
  output logic [15:0]              sel_wdata,
  input  wire logic [15:0]         sel_rdata,
  input  wire logic                sel_user_ok,
  // state shown to the rest of the chip
  output logic                     map_select_bit,
  output logic [3:0]               ext_addr_hi
);

  logic        map_sel_reg, map_sel_next;
  logic        map_wr_done_reg, map_wr_done_next;
  logic [15:0] priv_reg, priv_next;
  mrd_pkg::mrd_rsp_type rsp_reg, rsp_next;
  logic        sel_valid_reg, sel_valid_next;
  logic        sel_write_reg, sel_write_next;
  logic [11:0] sel_offset_reg, sel_offset_next;
  logic [15:0] sel_wdata_reg, sel_wdata_next;
  logic [3:0]  ext_hi_reg, ext_hi_next;

  logic [23:0] eff_addr;
  logic        hit;
  logic [11:0] offs;
  logic        priv_ok;

  // supervisor-only classed registers: offsets below 0x0A, 0x16, 0x1E, 0x20-0x2C,
  // 0x30-0x38 and from 0x44 up; everything else in this map is programmable
  function automatic logic is_super_only(input logic [11:0] o);
    is_super_only = (o < mrd_pkg::SUP_LOW_END) ||
                    (o == mrd_pkg::SUP_SINGLE_A) ||
                    (o == mrd_pkg::SUP_SINGLE_B) ||
                    ((o >= mrd_pkg::SUP_SYS_FIRST) && (o <= mrd_pkg::SUP_SYS_LAST)) ||
                    ((o >= mrd_pkg::SUP_TEST_FIRST) && (o <= mrd_pkg::SUP_TEST_LAST)) ||
                    (o >= mrd_pkg::SUP_HIGH_FIRST);
  endfunction : is_super_only

  // effective address: narrow core mirrors line 19 onto 23:20
  always_comb begin
    eff_addr = bus_req.addr;
    if (narrow_core) begin
      eff_addr[23:20] = {4{bus_req.addr[19]}}; // see (R6)
    end
  end

  always_comb begin
    offs = eff_addr[11:0]; // see (R11) (R13)
    hit  = eff_addr[23:12] == (map_sel_reg ? mrd_pkg::BASE_HIGH_HI
                                           : mrd_pkg::BASE_LOW_HI); // see (R1) (R2) (R3) (R13)
    // narrow core in low map: mirrored lines can never reach 7FF; see (R7)
    if (narrow_core && !map_sel_reg) begin
      hit = 1'b0; // see (R7)
    end
    if (narrow_core || bus_req.supervisor) begin
      priv_ok = 1'b1; // see (R10)
    end else if (is_super_only(offs)) begin
      priv_ok = 1'b0; // see (R8)
    end else begin
      priv_ok = !priv_reg[0] && sel_user_ok; // see (R9)
    end
  end

  always_comb begin
    map_sel_next     = map_sel_reg;
    map_wr_done_next = map_wr_done_reg;
    priv_next        = priv_reg;
    rsp_next         = '0;
    sel_valid_next   = 1'b0;
    sel_write_next   = 1'b0;
    sel_offset_next  = sel_offset_reg;
    sel_wdata_next   = sel_wdata_reg;
    if (bus_req.valid) begin
      rsp_next.ack = 1'b1;
      if (!hit || !priv_ok) begin
        rsp_next.err = 1'b1; // see (R8)
      end else begin
        sel_valid_next  = 1'b1;
        sel_write_next  = bus_req.write;
        sel_offset_next = offs;
        sel_wdata_next  = bus_req.wdata; // see (R12)
        if (bus_req.write && offs == mrd_pkg::CFG_OFFSET) begin
          if (!map_wr_done_reg) begin
            map_sel_next = bus_req.wdata[mrd_pkg::MAP_SEL_POS]; // see (R4)
          end
          map_wr_done_next = 1'b1; // see (R4)
        end
        if (bus_req.write && offs == mrd_pkg::PRIV_OFFSET) begin
          priv_next = bus_req.wdata; // see (R9)
        end
        if (!bus_req.write) begin
          if (offs == mrd_pkg::CFG_OFFSET) begin
            rsp_next.rdata = mrd_pkg::CFG_RST;
            rsp_next.rdata[mrd_pkg::MAP_SEL_POS] = map_sel_reg;
          end else if (offs == mrd_pkg::PRIV_OFFSET) begin
            rsp_next.rdata = priv_reg;
          end else begin
            rsp_next.rdata = sel_rdata;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      map_sel_reg     <= mrd_pkg::MAP_SEL_RST; // see (R4)
      map_wr_done_reg <= 1'b0;
      priv_reg        <= mrd_pkg::PRIV_RST;
      rsp_reg         <= '0;
      sel_valid_reg   <= 1'b0;
      sel_write_reg   <= 1'b0;
      sel_offset_reg  <= mrd_pkg::SEL_OFFSET_RST;
      sel_wdata_reg   <= mrd_pkg::SEL_WDATA_RST;
    end else begin
      map_sel_reg     <= map_sel_next;
      map_wr_done_reg <= map_wr_done_next;
      priv_reg        <= priv_next;
      rsp_reg         <= rsp_next;
      sel_valid_reg   <= sel_valid_next;
      sel_write_reg   <= sel_write_next;
      sel_offset_reg  <= sel_offset_next;
      sel_wdata_reg   <= sel_wdata_next;
    end
  end

  // high address lines: wide parts pass the bus, narrow parts mirror line 19 unless ext_hi_drive selects ext_hi_addr
  always_comb begin
    if (!narrow_core) begin
      ext_hi_next = bus_req.addr[23:20];
    end else if (ext_hi_drive) begin
      ext_hi_next = ext_hi_addr; // see (R6)
    end else begin
      ext_hi_next = {4{bus_req.addr[19]}}; // see (R6)
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_hi_reg <= mrd_pkg::EXT_HI_RST;
    end else begin
      ext_hi_reg <= ext_hi_next;
    end
  end

  assign bus_rsp        = rsp_reg;
  assign sel_valid      = sel_valid_reg;
  assign sel_write      = sel_write_reg;
  assign sel_offset     = sel_offset_reg;
  assign sel_wdata      = sel_wdata_reg;
  assign map_select_bit = map_sel_reg;
  assign ext_addr_hi    = ext_hi_reg;

  // checks: map select and block decode
  a_map_write_once: assert property ( // see (R4)
    @(posedge mclk) disable iff (!nrst)
    map_wr_done_reg |=> map_sel_reg == $past(map_sel_reg))
    else $error("map select changed after its single write");
  a_done_sticky: assert property ( // see (R4)
    @(posedge mclk) disable iff (!nrst)
    map_wr_done_reg |=> map_wr_done_reg)
    else $error("write-once marker dropped before reset");
  a_map_first_write: assert property ( // see (R4)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && bus_req.write && hit && priv_ok && !map_wr_done_reg &&
     offs == mrd_pkg::CFG_OFFSET)
    |=> map_sel_reg == $past(bus_req.wdata[mrd_pkg::MAP_SEL_POS]))
    else $error("first config write did not set map select");
  a_map_readback: assert property ( // see (R4)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !bus_req.write && hit && priv_ok && offs == mrd_pkg::CFG_OFFSET)
    |=> bus_rsp.rdata[mrd_pkg::MAP_SEL_POS] == $past(map_sel_reg))
    else $error("config read does not show map select");
  a_hit_high_map: assert property ( // see (R3)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && map_sel_reg && !narrow_core && bus_req.supervisor &&
     bus_req.addr[23:12] == 12'hFFF) |=> sel_valid && !bus_rsp.err)
    else $error("high map access not selected");
  a_hit_low_map: assert property ( // see (R2)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !map_sel_reg && !narrow_core && bus_req.supervisor &&
     bus_req.addr[23:12] == 12'h7FF) |=> sel_valid && !bus_rsp.err)
    else $error("low map access not selected");
  a_miss_errs: assert property ( // see (R1) (R13)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !narrow_core &&
     bus_req.addr[23:12] != (map_sel_reg ? 12'hFFF : 12'h7FF))
    |=> bus_rsp.ack && bus_rsp.err && !sel_valid)
    else $error("access outside block not refused");
  a_offset_pass: assert property ( // see (R11)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && hit && priv_ok) |=> sel_offset == $past(bus_req.addr[11:0]))
    else $error("offset not taken from low address bits");
  a_narrow_lockout: assert property ( // see (R7)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && narrow_core && !map_sel_reg) |=> bus_rsp.err)
    else $error("narrow core reached block with low map");
  a_narrow_high_hit: assert property ( // see (R6)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && narrow_core && map_sel_reg && bus_req.addr[19:12] == 8'hFF)
    |=> sel_valid && !bus_rsp.err)
    else $error("mirrored narrow address not decoded");

  // checks: answer and select pipeline
  a_ack_each_req: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    bus_req.valid |=> bus_rsp.ack)
    else $error("request not acknowledged in the next cycle");
  a_ack_only_req: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    !bus_req.valid |=> !bus_rsp.ack && !sel_valid)
    else $error("answer or select without a request");
  a_err_needs_ack: assert property ( // see (R1)
    @(posedge mclk) disable iff (!nrst)
    bus_rsp.err |-> bus_rsp.ack)
    else $error("error shown without acknowledge");
  a_sel_no_err: assert property ( // see (R1)
    @(posedge mclk) disable iff (!nrst)
    sel_valid |-> bus_rsp.ack && !bus_rsp.err)
    else $error("select raised on a refused access");
  a_write_data_pass: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && bus_req.write)
    |=> bus_rsp.err || (sel_write && sel_wdata == $past(bus_req.wdata)))
    else $error("write not passed to the modules");
  a_read_no_write: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !bus_req.write) |=> !sel_write)
    else $error("read turned into a write");
  a_module_read: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !bus_req.write && hit && priv_ok &&
     offs != mrd_pkg::CFG_OFFSET && offs != mrd_pkg::PRIV_OFFSET)
    |=> bus_rsp.rdata == $past(sel_rdata))
    else $error("module read data not returned");

  // checks: privilege
  a_super_only: assert property ( // see (R8)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && !narrow_core && !bus_req.supervisor && is_super_only(offs))
    |=> !sel_valid)
    else $error("user access reached supervisor register");
  a_user_gate: assert property ( // see (R9)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && hit && !narrow_core && !bus_req.supervisor &&
     !is_super_only(offs) && priv_reg[0]) |=> bus_rsp.err)
    else $error("user access allowed while restricted");
  a_user_open: assert property ( // see (R9)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && hit && !narrow_core && !bus_req.supervisor &&
     !is_super_only(offs) && !priv_reg[0] && sel_user_ok) |=> sel_valid)
    else $error("permitted user access refused");
  a_priv_write: assert property ( // see (R9)
    @(posedge mclk) disable iff (!nrst)
    (bus_req.valid && bus_req.write && hit && priv_ok && offs == mrd_pkg::PRIV_OFFSET)
    |=> priv_reg == $past(bus_req.wdata))
    else $error("privilege register write lost");
  a_priv_hold: assert property ( // see (R9)
    @(posedge mclk) disable iff (!nrst)
    !(bus_req.valid && bus_req.write && hit && priv_ok && offs == mrd_pkg::PRIV_OFFSET)
    |=> priv_reg == $past(priv_reg))
    else $error("privilege register changed without a write");

  // checks: high address lines
  a_mirror_hi: assert property ( // see (R6)
    @(posedge mclk) disable iff (!nrst)
    (narrow_core && !ext_hi_drive) |=> ext_addr_hi == {4{$past(bus_req.addr[19])}})
    else $error("high address lines do not follow line 19");
  a_ext_drive: assert property ( // see (R6)
    @(posedge mclk) disable iff (!nrst)
    (narrow_core && ext_hi_drive) |=> ext_addr_hi == $past(ext_hi_addr))
    else $error("external drive of high lines ignored");
  a_wide_hi_pass: assert property ( // see (R12)
    @(posedge mclk) disable iff (!nrst)
    !narrow_core |=> ext_addr_hi == $past(bus_req.addr[23:20]))
    else $error("wide part high lines do not follow the bus");

  c_high_write: cover property (@(posedge mclk) disable iff (!nrst)
    bus_req.valid && bus_req.write && hit && offs == mrd_pkg::CFG_OFFSET);
  c_low_map: cover property (@(posedge mclk) disable iff (!nrst)
    !map_sel_reg ##1 sel_valid);
  c_user_refused: cover property (@(posedge mclk) disable iff (!nrst)
    bus_req.valid && hit && !priv_ok);
  c_map_ignored: cover property (@(posedge mclk) disable iff (!nrst)
    bus_req.valid && bus_req.write && hit && offs == mrd_pkg::CFG_OFFSET && map_wr_done_reg);
  c_narrow_locked: cover property (@(posedge mclk) disable iff (!nrst)
    bus_req.valid && narrow_core && !map_sel_reg);

endmodule : mrd_decode

/* test/mrd_cpu_model.sv */
// bus master model of the core issuing register accesses
`timescale 1ns/1ps
module mrd_cpu_model (
  // clock and variant strap
  input  wire logic                 mclk,
  input  wire logic                 narrow_core,
  // intermodule bus
  output mrd_pkg::mrd_req_type      bus_req,
  input  wire mrd_pkg::mrd_rsp_type bus_rsp
);
  initial bus_req = '0;

  // one access; the answer is taken one cycle after the request edge
  task automatic access(input logic wr, input logic sup, input logic [23:0] adr,
                        input logic [15:0] wd, output mrd_pkg::mrd_rsp_type rsp);
    @(posedge mclk);
    #1;
    // the narrow core has no user level
    bus_req = '{1'b1, wr, sup | narrow_core, adr, wd};
    @(posedge mclk);
    #1;
    rsp = bus_rsp;
    // released lines show the inverse so stale values cannot match
    bus_req = '{1'b0, ~wr, ~sup, ~adr, ~wd};
  endtask : access
endmodule : mrd_cpu_model

/* test/mrd_decode_bench.sv */
// self-checking bench for the register block decoder
`timescale 1ns/1ps
module mrd_decode_bench;
  logic                 mclk;
  logic                 nrst;
  logic                 narrow_core;
  logic                 ext_hi_drive;
  logic [3:0]           ext_hi_addr;
  mrd_pkg::mrd_req_type bus_req;
  mrd_pkg::mrd_rsp_type bus_rsp;
  mrd_pkg::mrd_rsp_type rsp;
  logic                 sel_valid;
  logic                 sel_write;
  logic [11:0]          sel_offset;
  logic [15:0]          sel_wdata;
  logic [15:0]          sel_rdata;
  logic                 sel_user_ok;
  logic                 map_select_bit;
  logic [3:0]           ext_addr_hi;
  int                   err_count;
  int                   num_checks;

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  mrd_decode dut (.mclk(mclk), .nrst(nrst), .narrow_core(narrow_core),
    .ext_hi_drive(ext_hi_drive), .ext_hi_addr(ext_hi_addr), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .sel_valid(sel_valid), .sel_write(sel_write),
    .sel_offset(sel_offset), .sel_wdata(sel_wdata), .sel_rdata(sel_rdata),
    .sel_user_ok(sel_user_ok), .map_select_bit(map_select_bit),
    .ext_addr_hi(ext_addr_hi));
  mrd_cpu_model cpu (.mclk(mclk), .narrow_core(narrow_core), .bus_req(bus_req),
    .bus_rsp(bus_rsp));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one access, then judge the answer and the decoded select
  task automatic acc(input logic wr, input logic sup, input logic [23:0] a,
                     input logic [15:0] wd, input logic e);
    cpu.access(wr, sup, a, wd, rsp);
    chk(rsp.ack, 1'b1);
    chk(rsp.err, e);
    chk(sel_valid, !e);
    if (!e) begin
      chk(sel_offset, a[11:0]);
      chk(sel_write, wr);
      chk(sel_wdata, wd);
    end
  endtask : acc

  task automatic do_reset();
    nrst = 1'b0;
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
  endtask : do_reset

  task automatic t_priv();
    chk(map_select_bit, 1'b1);
    acc(0, 1, 24'hFFF000, 16'h0000, 0);
    chk(rsp.rdata, mrd_pkg::CFG_RST);
    acc(1, 1, 24'hFFF000, 16'h0040, 0);
    acc(1, 1, 24'hFFF000, 16'h0000, 0);
    acc(0, 1, 24'hFFFFFE, 16'h0000, 0);
    acc(0, 1, 24'hFFEFFE, 16'h0000, 1);
    acc(0, 1, 24'h7FF000, 16'h0000, 1);
    acc(0, 0, 24'hFFF004, 16'h0000, 1);
    acc(0, 1, 24'hFFF004, 16'h0000, 0);
    acc(0, 0, 24'hFFF00A, 16'h0000, 0);
    chk(rsp.rdata, 16'hA55A);
    sel_user_ok = 1'b0;
    acc(0, 0, 24'hFFF00C, 16'h0000, 1);
    sel_user_ok = 1'b1;
    acc(1, 1, 24'hFFF002, 16'h0001, 0);
    acc(0, 1, 24'hFFF002, 16'h0000, 0);
    chk(rsp.rdata, 16'h0001);
    acc(0, 0, 24'hFFF00A, 16'h0000, 1);
    chk(map_select_bit, 1'b1);
    $display("test priv done");
  endtask : t_priv

  task automatic t_map();
    acc(1, 1, 24'hFFF000, 16'h0000, 0);
    @(posedge mclk);
    #1 chk(map_select_bit, 1'b0);
    acc(0, 1, 24'h7FF010, 16'h0000, 0);
    acc(1, 1, 24'h7FF000, 16'h0040, 0);
    @(posedge mclk);
    #1 chk(map_select_bit, 1'b0);
    acc(0, 1, 24'hFFF010, 16'h0000, 1);
    $display("test map done");
  endtask : t_map

  task automatic t_narrow();
    acc(0, 0, 24'hFFF004, 16'h0000, 0);
    chk(ext_addr_hi, 4'hF);
    acc(0, 1, 24'h0FF002, 16'h0000, 0);
    chk(ext_addr_hi, 4'hF);
    acc(0, 1, 24'hF7F002, 16'h0000, 1);
    chk(ext_addr_hi, 4'h0);
    ext_hi_drive = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(ext_addr_hi, 4'h9);
    ext_hi_drive = 1'b0;
    acc(1, 1, 24'hFFF000, 16'h0000, 0);
    acc(0, 1, 24'h7FF000, 16'h0000, 1);
    acc(0, 1, 24'hFFF000, 16'h0000, 1);
    $display("test narrow done");
  endtask : t_narrow

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    err_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    narrow_core = 1'b0;
    ext_hi_drive = 1'b0;
    ext_hi_addr = 4'h9;
    sel_rdata = 16'hA55A;
    sel_user_ok = 1'b1;
    do_reset();
    t_priv();
    do_reset();
    t_map();
    narrow_core = 1'b1;
    do_reset();
    t_narrow();
    give_verdict();
  end

  // watchdog far beyond the fewer than a hundred cycles the tests need
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule : mrd_decode_bench
